// File: design/cms_map.vh
// constants for the cpu mode and status controller
// assumes a 10 mhz aclk and an axi4-lite register bus
`ifndef CMS_MAP_VH
`define CMS_MAP_VH
`define CMS_CLK_MHZ 10
`define CMS_SLOW_MS 500
`define CMS_FAST_MS 125
`define CMS_SLOW_CYC (`CMS_SLOW_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_FAST_CYC (`CMS_FAST_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_OFS_CTRL 8'h00
`define CMS_OFS_STAT 8'h04
`define CMS_OFS_IRQ_STAT 8'h08
`define CMS_OFS_IRQ_EN 8'h0c
`define CMS_OFS_IRQ_CLR 8'h10
`define CMS_CTRL_RST 4'h0
`define CMS_IRQ_EN_RST 4'h0
`define CMS_CTRL_PG_STOP 0
`define CMS_CTRL_SELF_STOP 1
`define CMS_CTRL_ORST_REQ 2
`define CMS_CTRL_CHECK 3
`define CMS_ST_STOP 3'h0
`define CMS_ST_RUN 3'h1
`define CMS_ST_INIT 3'h2
`define CMS_ST_ERASE 3'h3
`define CMS_ST_CLEAR 3'h4
`define CMS_ST_CHECK 3'h5
`define CMS_WHY_USER 2'h0
`define CMS_WHY_SELF 2'h1
`define CMS_WHY_ORST 2'h2
`define CMS_WHY_ORDONE 2'h3
`define CMS_EV_RUN 0
`define CMS_EV_STOP 1
`define CMS_EV_ERASE 2
`define CMS_EV_CLEAR 3
`define CMS_STARTUP_BLOCK 8'h14
`define CMS_ERASE_CYC 16
`endif

// File: design/cms_flash.v
// toggle generator for slow and rapid indicator flashing
// assumes one free-running clock
`timescale 1ns/100ps
`default_nettype none
`include "cms_map.vh"
module cms_flash #(
    parameter SLOW_CYC = `CMS_SLOW_CYC,
    parameter FAST_CYC = `CMS_FAST_CYC
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // flash levels
    output reg slow_reg,
    output reg fast_reg
);
    reg [31:0] slow_cnt_reg;
    reg [31:0] fast_cnt_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            slow_cnt_reg <= 32'h0;
            fast_cnt_reg <= 32'h0;
            slow_reg <= 1'b0;
            fast_reg <= 1'b0;
        end else begin
            // two fixed, distinct periods
            if (slow_cnt_reg >= SLOW_CYC - 1) begin
                slow_cnt_reg <= 32'h0;
                slow_reg <= ~slow_reg;
            end else begin
                slow_cnt_reg <= slow_cnt_reg + 32'h1;
            end
            if (fast_cnt_reg >= FAST_CYC - 1) begin
                fast_cnt_reg <= 32'h0;
                fast_reg <= ~fast_reg;
            end else begin
                fast_cnt_reg <= fast_cnt_reg + 32'h1;
            end
        end
    end
endmodule // cms_flash
`default_nettype wire

// File: design/cms_ctrl.v
// cpu operating-mode controller with run/stop indicators and axi4-lite regs
// assumes switch inputs already debounced and synchronous to aclk
// How it works
// - program runs only while run indicator on
// - selector run to stop enters stop, lit
// - overall reset erases all ram areas
// - reset clears state, startup block, restarts
// - restart resumes, keeps flags and timers
// - running shows run on, stop off
// - user or peer stop: stop steady
// - initial start or check: both off
// - self stop is signalled to peers
// - pending overall reset: stopped, rapid flash
// - overall reset done: stop steady lit
// - output inhibit blocks outputs to safe
`timescale 1ns/100ps
`default_nettype none
`include "cms_map.vh"
module cms_ctrl #(
    parameter SLOW_CYC = `CMS_SLOW_CYC,
    parameter FAST_CYC = `CMS_FAST_CYC,
    parameter ERASE_CYC = `CMS_ERASE_CYC
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // operator switches
    input wire selector_run,
    input wire momentary_switch_down,
    input wire momentary_switch_up,
    // peer cpus
    input wire peer_stop_in,
    output reg peer_stop_out_reg,
    // program engine side
    output reg exec_enable_reg,
    output reg resume_pulse_reg,
    output reg cold_start_pulse_reg,
    output reg [7:0] startup_handler_block_reg,
    output reg erase_ram_reg,
    output reg erase_submodule_reg,
    output reg clear_state_reg,
    output reg output_inhibit_reg,
    // indicators
    output reg run_led_reg,
    output reg stop_led_reg,
    output wire irq,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [1:0] why_reg;
    reg [1:0] why_next;
    reg sel_q_reg;
    reg [15:0] cnt_reg;
    reg [3:0] ctrl_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_en_reg;
    reg [3:0] ev;
    reg aw_got_reg;
    reg w_got_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire slow_flash;
    wire fast_flash;
    wire sel_to_stop;
    wire sel_to_run;
    wire cnt_done;

    // one decode shared by execution, indicator and inhibit paths
    function is_live(input [2:0] st);
        is_live = (st == `CMS_ST_RUN);
    endfunction

    cms_flash #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_flash (
        .aclk(aclk),
        .aresetn(aresetn),
        .slow_reg(slow_flash),
        .fast_reg(fast_flash)
    );

    assign sel_to_stop = sel_q_reg & ~selector_run;
    assign sel_to_run = ~sel_q_reg & selector_run;
    assign cnt_done = (cnt_reg == ERASE_CYC - 1);

    // mode sequencing
    always @* begin
        state_next = state_reg;
        why_next = why_reg;
        ev = 4'h0;
        case (state_reg)
            `CMS_ST_INIT: begin
                // power-up always lands in stop with overall reset pending
                state_next = `CMS_ST_STOP;
                why_next = `CMS_WHY_ORST;
            end
            `CMS_ST_RUN: begin
                if (!selector_run || ctrl_reg[`CMS_CTRL_PG_STOP] || peer_stop_in) begin
                    state_next = `CMS_ST_STOP;
                    why_next = `CMS_WHY_USER;
                    ev[`CMS_EV_STOP] = 1'b1;
                end else if (ctrl_reg[`CMS_CTRL_ORST_REQ]) begin
                    state_next = `CMS_ST_STOP;
                    why_next = `CMS_WHY_ORST;
                    ev[`CMS_EV_STOP] = 1'b1;
                end else if (ctrl_reg[`CMS_CTRL_SELF_STOP]) begin
                    state_next = `CMS_ST_STOP;
                    why_next = `CMS_WHY_SELF;
                    ev[`CMS_EV_STOP] = 1'b1;
                end else if (ctrl_reg[`CMS_CTRL_CHECK]) begin
                    state_next = `CMS_ST_CHECK;
                end
            end
            `CMS_ST_CHECK: begin
                // a stop request must not be lost while the program is checked
                if (!selector_run || ctrl_reg[`CMS_CTRL_PG_STOP] || peer_stop_in) begin
                    state_next = `CMS_ST_STOP;
                    why_next = `CMS_WHY_USER;
                    ev[`CMS_EV_STOP] = 1'b1;
                end else if (!ctrl_reg[`CMS_CTRL_CHECK]) begin
                    state_next = `CMS_ST_RUN;
                end
            end
            `CMS_ST_STOP: begin
                if (ctrl_reg[`CMS_CTRL_ORST_REQ] && why_reg != `CMS_WHY_ORDONE) begin
                    why_next = `CMS_WHY_ORST;
                end else if (why_reg == `CMS_WHY_SELF && sel_to_stop) begin
                    why_next = `CMS_WHY_USER;
                end
                if (sel_to_run) begin
                    if (momentary_switch_down) begin
                        state_next = `CMS_ST_ERASE;
                    end else if (momentary_switch_up) begin
                        state_next = `CMS_ST_CLEAR;
                    end else if (why_reg != `CMS_WHY_ORST && !peer_stop_in &&
                                 !ctrl_reg[`CMS_CTRL_PG_STOP]) begin
                        state_next = `CMS_ST_RUN;
                        ev[`CMS_EV_RUN] = 1'b1;
                    end
                end
            end
            `CMS_ST_ERASE: begin
                if (cnt_done) begin
                    state_next = `CMS_ST_STOP;
                    why_next = `CMS_WHY_ORDONE;
                    ev[`CMS_EV_ERASE] = 1'b1;
                end
            end
            `CMS_ST_CLEAR: begin
                if (cnt_done) begin
                    state_next = `CMS_ST_RUN;
                    why_next = `CMS_WHY_USER;
                    ev[`CMS_EV_CLEAR] = 1'b1;
                    ev[`CMS_EV_RUN] = 1'b1;
                end
            end
            default: begin
                state_next = `CMS_ST_INIT;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= `CMS_ST_INIT;
            why_reg <= `CMS_WHY_USER;
            sel_q_reg <= 1'b0;
            cnt_reg <= 16'h0;
            exec_enable_reg <= 1'b0;
            resume_pulse_reg <= 1'b0;
            cold_start_pulse_reg <= 1'b0;
            startup_handler_block_reg <= 8'h0;
            erase_ram_reg <= 1'b0;
            erase_submodule_reg <= 1'b0;
            clear_state_reg <= 1'b0;
            output_inhibit_reg <= 1'b1;
            run_led_reg <= 1'b0;
            stop_led_reg <= 1'b0;
            peer_stop_out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            why_reg <= why_next;
            sel_q_reg <= selector_run;
            cnt_reg <= (state_next == state_reg && (state_reg == `CMS_ST_ERASE ||
                        state_reg == `CMS_ST_CLEAR)) ? cnt_reg + 16'h1 : 16'h0;
            // run indicator and execution move together
            exec_enable_reg <= is_live(state_next);
            run_led_reg <= is_live(state_next);
            // resume keeps flags, timers, counters and image untouched
            resume_pulse_reg <= ev[`CMS_EV_RUN] & ~ev[`CMS_EV_CLEAR];
            cold_start_pulse_reg <= ev[`CMS_EV_CLEAR];
            startup_handler_block_reg <= `CMS_STARTUP_BLOCK;
            erase_ram_reg <= (state_next == `CMS_ST_ERASE);
            erase_submodule_reg <= (state_next == `CMS_ST_ERASE);
            clear_state_reg <= (state_next == `CMS_ST_CLEAR);
            // outputs held safe whenever not running
            output_inhibit_reg <= ~is_live(state_next);
            peer_stop_out_reg <= (state_next == `CMS_ST_STOP) &&
                                 (why_next == `CMS_WHY_SELF);
            case (state_next)
                `CMS_ST_STOP: begin
                    case (why_next)
                        `CMS_WHY_SELF: stop_led_reg <= slow_flash;
                        `CMS_WHY_ORST: stop_led_reg <= fast_flash;
                        default: stop_led_reg <= 1'b1;
                    endcase
                end
                default: stop_led_reg <= 1'b0;
            endcase
        end
    end

    // axi4-lite slave, one write and one read at a time
    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            ctrl_reg <= `CMS_CTRL_RST;
            irq_en_reg <= `CMS_IRQ_EN_RST;
            irq_stat_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            // set wins over clear
            irq_stat_reg <= irq_stat_reg | ev;
            if (aw_got_reg && w_got_reg) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_addr_reg)
                    `CMS_OFS_CTRL: if (w_strb_reg[0]) ctrl_reg <= w_data_reg[3:0];
                    `CMS_OFS_IRQ_EN: if (w_strb_reg[0]) irq_en_reg <= w_data_reg[3:0];
                    `CMS_OFS_IRQ_CLR: if (w_strb_reg[0])
                        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[3:0]) | ev;
                    `CMS_OFS_STAT, `CMS_OFS_IRQ_STAT: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `CMS_OFS_CTRL: s_axi_rdata <= {28'h0, ctrl_reg};
                    `CMS_OFS_STAT: s_axi_rdata <= {25'h0, output_inhibit_reg,
                        why_reg, run_led_reg, state_reg};
                    `CMS_OFS_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_reg};
                    `CMS_OFS_IRQ_EN: s_axi_rdata <= {28'h0, irq_en_reg};
                    `CMS_OFS_IRQ_CLR: s_axi_rdata <= 32'h0;
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);
endmodule // cms_ctrl
`default_nettype wire

// File: tb/cms_ctrl_asserts.sv
// port checker for the cpu mode controller
// bound to cms_ctrl from the bench top; one clock domain
`timescale 1ns/100ps
`default_nettype none
module cms_ctrl_asserts #(
    parameter ERASE_CYC = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // watched outputs
    input wire exec_enable_reg,
    input wire run_led_reg,
    input wire stop_led_reg,
    input wire output_inhibit_reg,
    input wire peer_stop_out_reg,
    input wire resume_pulse_reg,
    input wire cold_start_pulse_reg,
    input wire [7:0] startup_handler_block_reg,
    input wire erase_ram_reg,
    input wire erase_submodule_reg,
    input wire clear_state_reg
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // saturating so a stuck erase cannot wrap back to a legal count
    logic [7:0] erase_cnt;
    always @(posedge aclk) begin
        if (!aresetn || !erase_ram_reg) erase_cnt <= 8'h00;
        else if (erase_cnt != 8'hff) erase_cnt <= erase_cnt + 8'h01;
    end
    AST_EXEC_GATED: assert property (exec_enable_reg |-> run_led_reg)
        else $error("program runs with run indicator off");
    AST_LED_EXCL: assert property (run_led_reg |-> !stop_led_reg)
        else $error("both indicators lit");
    AST_INHIBIT_RUN: assert property ($fell(output_inhibit_reg) |-> ##[0:2] run_led_reg)
        else $error("outputs released outside run");
    AST_SELF_PEER: assert property (peer_stop_out_reg |-> !run_led_reg && output_inhibit_reg)
        else $error("peer stop signalled while running");
    AST_RESUME_ONE: assert property (resume_pulse_reg |=> !resume_pulse_reg)
        else $error("resume pulse too long");
    AST_COLD_BLOCK: assert property (cold_start_pulse_reg |->
        startup_handler_block_reg == 8'h14 ##1 !cold_start_pulse_reg)
        else $error("cold start block or pulse wrong");
    AST_COLD_RUN: assert property (cold_start_pulse_reg |-> ##[0:2] run_led_reg)
        else $error("no run after cold start");
    AST_ERASE_BOTH: assert property (erase_ram_reg |-> erase_submodule_reg && !run_led_reg)
        else $error("erase not on both ram areas");
    AST_ERASE_LEN: assert property ($fell(erase_ram_reg) |-> erase_cnt == ERASE_CYC)
        else $error("erase phase of wrong length");
    AST_CLEAR_STOP: assert property (clear_state_reg |-> !run_led_reg)
        else $error("clear while running");
    cover property ($rose(erase_ram_reg));
    cover property (cold_start_pulse_reg);
    cover property (resume_pulse_reg);
    cover property ($rose(peer_stop_out_reg));
endmodule // cms_ctrl_asserts
`default_nettype wire

// File: tb/cms_panel.sv
// operator panel and peer cpu model: selector, momentary switch, peer stop
// assumes the bench calls its tasks; changes land just after aclk rises
`timescale 1ns/100ps
`default_nettype none
module cms_panel (
    // clock
    input wire logic aclk,
    // operator switches
    output logic selector_run,
    output logic momentary_switch_down,
    output logic momentary_switch_up,
    // peer cpu
    output logic peer_stop_in
);
    initial begin
        selector_run = 1'h0;
        {momentary_switch_down, momentary_switch_up} = 2'h0;
        peer_stop_in = 1'h0;
    end
    // momentary switch held until the next operator action, not sprung back
    task automatic turn(input logic run, input logic [1:0] ms);
        @(posedge aclk);
        {momentary_switch_down, momentary_switch_up} <= ms;
        repeat (2) @(posedge aclk);
        selector_run <= run;
    endtask
    task automatic peer(input logic v);
        @(posedge aclk);
        peer_stop_in <= v;
    endtask
endmodule // cms_panel
`default_nettype wire

// File: tb/cms_ctrl_tb_top.sv
// bench for the cpu mode controller: bus tasks and scenarios
// assumes cms_panel and cms_ctrl_asserts compiled before it
`timescale 1ns/100ps
`default_nettype none
module cms_ctrl_tb_top;
    localparam int ERASE = 4;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] r;
    logic s;
    wire selector_run, momentary_switch_down, momentary_switch_up, peer_stop_in, irq;
    wire peer_stop_out_reg, exec_enable_reg, resume_pulse_reg, cold_start_pulse_reg;
    wire erase_ram_reg, erase_submodule_reg, clear_state_reg, output_inhibit_reg;
    wire run_led_reg, stop_led_reg, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [7:0] startup_handler_block_reg;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int fail_count = 0, n_compared = 0, cyc = 0, t;
    always #50 aclk = ~aclk;
    cms_panel u_panel (.aclk, .selector_run, .momentary_switch_down, .momentary_switch_up,
        .peer_stop_in);
    cms_ctrl #(.SLOW_CYC(8), .FAST_CYC(2), .ERASE_CYC(ERASE)) DUT (.aclk, .aresetn,
        .selector_run, .momentary_switch_down, .momentary_switch_up, .peer_stop_in,
        .peer_stop_out_reg, .exec_enable_reg, .resume_pulse_reg, .cold_start_pulse_reg,
        .startup_handler_block_reg, .erase_ram_reg, .erase_submodule_reg,
        .clear_state_reg, .output_inhibit_reg, .run_led_reg, .stop_led_reg, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input bit ok, input string m);
        n_compared++;
        if (!ok) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // toggles of the stop indicator over 32 cycles; a lit run indicator spoils it
    task automatic flash();
        repeat (4) @(posedge aclk);
        t = 0;
        s = stop_led_reg;
        repeat (32) begin
            @(posedge aclk);
            if (stop_led_reg !== s || run_led_reg !== 1'h0) t++;
            s = stop_led_reg;
        end
    endtask
    task automatic go_run();
        u_panel.turn(1'h1, 2'h0);
        for (int i = 0; i < 20 && resume_pulse_reg !== 1'h1; i++) @(posedge aclk);
        chk(resume_pulse_reg === 1'h1, "no resume");
        repeat (3) @(posedge aclk);
        chk(run_led_reg === 1'h1 && stop_led_reg === 1'h0, "leds in run");
        chk(exec_enable_reg === 1'h1 && output_inhibit_reg === 1'h0, "not live");
    endtask
    task automatic t_power();
        flash();
        chk(t == 16 && output_inhibit_reg === 1'h1, "no rapid flash");
        rd(8'h00);
        chk(d[3:0] === 4'h0, "ctrl reset value");
        rd(8'h0c);
        chk(d[3:0] === 4'h0, "irq enable reset value");
        rd(8'h20);
        chk(r === 2'h2 && d === 32'h0, "unmapped read");
        wr(8'h20, 32'h0);
        chk(r === 2'h2, "unmapped write");
    endtask
    task automatic t_orst();
        wr(8'h0c, 32'hf);
        chk(r === 2'h0, "write refused");
        u_panel.turn(1'h1, 2'h2);
        for (int i = 0; i < 20 && erase_ram_reg !== 1'h1; i++) @(posedge aclk);
        chk(erase_submodule_reg === 1'h1, "no erase");
        flash();
        chk(t == 0 && s === 1'h1, "stop not steady");
        rd(8'h08);
        chk(d[2] === 1'h1 && irq === 1'h1, "no erase event");
        wr(8'h0c, 32'h0);
        chk(irq === 1'h0, "irq not masked");
        wr(8'h10, 32'hf);
        rd(8'h08);
        chk(d[3:0] === 4'h0, "irq not cleared");
    endtask
    task automatic t_reset();
        bit cs;
        cs = 1'b0;
        u_panel.turn(1'h0, 2'h0);
        u_panel.turn(1'h1, 2'h1);
        for (int i = 0; i < 30 && cold_start_pulse_reg !== 1'h1; i++) begin
            @(posedge aclk);
            cs |= clear_state_reg === 1'h1;
        end
        chk(cs && startup_handler_block_reg === 8'h14, "no clear or block");
        repeat (3) @(posedge aclk);
        chk(run_led_reg === 1'h1 && output_inhibit_reg === 1'h0, "no cold run");
    endtask
    task automatic t_stops();
        u_panel.turn(1'h0, 2'h0);
        flash();
        chk(t == 0 && s === 1'h1 && exec_enable_reg === 1'h0, "no user stop");
        go_run();
        u_panel.peer(1'h1);
        flash();
        chk(t == 0 && s === 1'h1, "no peer stop");
        u_panel.peer(1'h0);
        u_panel.turn(1'h0, 2'h0);
        go_run();
        wr(8'h00, 32'h1);
        flash();
        chk(t == 0 && s === 1'h1, "no unit stop");
        wr(8'h00, 32'h0);
        u_panel.turn(1'h0, 2'h0);
        go_run();
    endtask
    task automatic t_self();
        wr(8'h00, 32'h2);
        flash();
        chk(t == 4, "no slow flash");
        chk(peer_stop_out_reg === 1'h1, "peers not told");
        u_panel.turn(1'h0, 2'h0);
        flash();
        chk(t == 0 && s === 1'h1, "flash not steady");
        wr(8'h00, 32'h0);
        go_run();
        wr(8'h00, 32'h8);
        repeat (4) @(posedge aclk);
        chk(run_led_reg === 1'h0 && stop_led_reg === 1'h0, "leds in check");
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_power();
        t_orst();
        t_reset();
        t_stops();
        t_self();
        end_sim();
    end
endmodule // cms_ctrl_tb_top
bind cms_ctrl cms_ctrl_asserts #(.ERASE_CYC(ERASE_CYC)) u_chk (.aclk, .aresetn,
    .exec_enable_reg, .run_led_reg, .stop_led_reg, .output_inhibit_reg, .peer_stop_out_reg,
    .resume_pulse_reg, .cold_start_pulse_reg, .startup_handler_block_reg, .erase_ram_reg,
    .erase_submodule_reg, .clear_state_reg);
`default_nettype wire
